// [include/pcrs_map.vh]
/*
 * pcrs_map.vh: constants for the program counter and return stack block.
 * assumes: included by bare name from hw/pcrs_core.v; definitions only.
 */
`ifndef PCRS_MAP_VH
`define PCRS_MAP_VH

`define PCRS_ADDR_W      21
`define PCRS_BYTE_W      8
`define PCRS_UPPER_W     5
`define PCRS_PTR_W       5
`define PCRS_DEPTH       31
`define PCRS_INSN_STEP   21'h000002
`define PCRS_RESET_ADDR  21'h000000
`define PCRS_PTR_RESET   5'h00
`define PCRS_HLAT_RESET  8'h00
`define PCRS_ULAT_RESET  5'h00
`define PCRS_PTR_ONE     5'h01
`define PCRS_PTR_FULL    5'h1F
`define PCRS_LOW_LSB     0
`define PCRS_HIGH_LSB    8
`define PCRS_UPPER_LSB   16

`endif

// [hw/pcrs_core.v]
/*
 * pcrs_core.v: program counter with high/upper latches and a 31-entry
 * return-address stack with software access to pointer and top entry.
 * assumes: one clock, synchronous reset; the decoder asserts at most one
 * of the pc-changing strobes per cycle and keeps software stack access
 * away from interrupt acknowledges.
 */
// Functional notes
// - 21-bit fetch address in three bytes
// - low byte accessible, high byte via latch
// - upper byte loaded only through upper latch
// - low byte write copies latches into pc
// - low byte read copies pc into latches
// - fetch address bit zero always zero
// - sequential fetch advances by two
// - calls, jumps, branches load pc directly
// - push on call or interrupt, 31 deep
// - pop into pc on any return; an empty stack loads address zero
// - call and return leave latches alone
// - 31 x 21 storage, 5-bit pointer
// - software reads/writes pointer and top entry
// - push increments pointer then writes pc plus two
// - pop reads entry then decrements pointer
// - reset clears pointer; zero has no entry
// - full, overflow, underflow status bits
// - top access registers track pointed entry
`timescale 1ns/10ps
`include "pcrs_map.vh"

module pcrs_core #(
   parameter DEPTH  = `PCRS_DEPTH,
   parameter PTR_W  = `PCRS_PTR_W,
   parameter ADDR_W = `PCRS_ADDR_W
) (
   input  wire              clk,              // core clock
   input  wire              rst,              // synchronous reset, active high
   input  wire              advance,          // fetch next sequential word
   input  wire              load_direct,      // call/jump/branch target load
   input  wire [ADDR_W-1:0] target_addr,      // direct target address
   input  wire              do_call,          // call or relative_call: push then load target
   input  wire              int_ack,          // interrupt acknowledge: push then load vector
   input  wire              do_return,        // return, return_with_literal, return_from_interrupt
   input  wire              low_wr,           // write fetch_addr_low_byte
   input  wire              low_rd,           // read fetch_addr_low_byte
   input  wire [7:0]        wr_data,          // data for any byte write
   input  wire              high_latch_wr,    // write high_byte_latch
   input  wire              upper_latch_wr,   // write upper_byte_latch
   input  wire              ptr_wr,           // write return_stack_pointer
   input  wire              top_upper_wr,     // write stack_top_upper
   input  wire              top_high_wr,      // write stack_top_high
   input  wire              top_low_wr,       // write stack_top_low
   input  wire              clr_overflow,     // clear sticky overflow
   input  wire              clr_underflow,    // clear sticky underflow
   output reg  [ADDR_W-1:0] fetch_addr,       // current fetch address
   output reg  [7:0]        fetch_addr_low_byte, // read data of low byte
   output reg  [7:0]        high_byte_latch,  // latch contents
   output reg  [4:0]        upper_byte_latch, // latch contents
   output reg  [PTR_W-1:0]  return_stack_pointer, // stack pointer
   output reg  [4:0]        stack_top_upper,  // top entry bits 20:16
   output reg  [7:0]        stack_top_high,   // top entry bits 15:8
   output reg  [7:0]        stack_top_low,    // top entry bits 7:0
   output reg               stack_full,       // pointer at last entry
   output reg               stack_overflow,   // sticky overflow
   output reg               stack_underflow   // sticky underflow
);

   reg [ADDR_W-1:0] pc_ff;
   reg [7:0]        hlat_ff;
   reg [4:0]        ulat_ff;
   reg [PTR_W-1:0]  ptr_ff;
   reg              ovf_ff;
   reg              unf_ff;
   reg [ADDR_W-1:0] stack_mem [1:DEPTH];

   reg [ADDR_W-1:0] nxt_pc;
   reg [7:0]        nxt_hlat;
   reg [4:0]        nxt_ulat;
   reg [PTR_W-1:0]  nxt_ptr;
   reg              nxt_ovf;
   reg              nxt_unf;
   reg              push_ok;
   reg              pop_ok;
   reg [ADDR_W-1:0] push_val;

   wire [ADDR_W-1:0] seq_pc = pc_ff + `PCRS_INSN_STEP;
   localparam [PTR_W-1:0] FULL_PTR = DEPTH;
   wire              at_full = (ptr_ff == FULL_PTR);
   wire              at_zero = (ptr_ff == `PCRS_PTR_RESET);
   wire [ADDR_W-1:0] top_val = at_zero ? `PCRS_RESET_ADDR : stack_mem[ptr_ff];

   // forces word alignment on the target, low-write and pop paths into the counter
   function [ADDR_W-1:0] align;
      input [ADDR_W-1:0] a;
      begin
         align = {a[ADDR_W-1:1], 1'b0};
      end
   endfunction

   always @* begin
      nxt_pc   = pc_ff;
      nxt_hlat = hlat_ff;
      nxt_ulat = ulat_ff;
      nxt_ptr  = ptr_ff;
      nxt_ovf  = ovf_ff;
      nxt_unf  = unf_ff;
      push_ok  = 1'b0;
      pop_ok   = 1'b0;
      push_val = seq_pc;
      if (clr_overflow)
         nxt_ovf = 1'b0;
      if (clr_underflow)
         nxt_unf = 1'b0;
      if (high_latch_wr)
         nxt_hlat = wr_data;
      if (upper_latch_wr)
         nxt_ulat = wr_data[`PCRS_UPPER_W-1:0];
      if (ptr_wr)
         nxt_ptr = wr_data[PTR_W-1:0];
      if (do_call || int_ack) begin
         // a full stack keeps its entries; only the sticky flag records it
         if (at_full) begin
            nxt_ovf = 1'b1;
         end else begin
            push_ok = 1'b1;
            nxt_ptr = ptr_ff + `PCRS_PTR_ONE;
         end
         nxt_pc = align(target_addr);
      end else if (do_return) begin
         if (at_zero) begin
            nxt_unf = 1'b1;
            nxt_pc  = `PCRS_RESET_ADDR;
         end else begin
            pop_ok  = 1'b1;
            nxt_pc  = align(stack_mem[ptr_ff]);
            nxt_ptr = ptr_ff - `PCRS_PTR_ONE;
         end
      end else if (low_wr) begin
         nxt_pc = align({ulat_ff, hlat_ff, wr_data});
      end else if (load_direct) begin
         nxt_pc = align(target_addr);
      end else if (advance) begin
         nxt_pc = seq_pc;
      end
      if (low_rd && !high_latch_wr && !upper_latch_wr) begin
         nxt_hlat = pc_ff[`PCRS_UPPER_LSB-1:`PCRS_HIGH_LSB];
         nxt_ulat = pc_ff[ADDR_W-1:`PCRS_UPPER_LSB];
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         pc_ff   <= `PCRS_RESET_ADDR;
         hlat_ff <= `PCRS_HLAT_RESET;
         ulat_ff <= `PCRS_ULAT_RESET;
         ptr_ff  <= `PCRS_PTR_RESET;
         ovf_ff  <= 1'b0;
         unf_ff  <= 1'b0;
      end else begin
         pc_ff   <= nxt_pc;
         hlat_ff <= nxt_hlat;
         ulat_ff <= nxt_ulat;
         ptr_ff  <= nxt_ptr;
         ovf_ff  <= nxt_ovf;
         unf_ff  <= nxt_unf;
      end
   end

   // storage carries no reset; entry contents are undefined until pushed or written through the top registers
   genvar gi;
   generate
      for (gi = 1; gi <= DEPTH; gi = gi + 1) begin : g_ent
         always @(posedge clk) begin
            if (push_ok && (nxt_ptr == gi)) begin
               stack_mem[gi] <= push_val;
            end else if (!push_ok && !pop_ok && (ptr_ff == gi)) begin
               // software top writes land in the entry the pointer selects
               if (top_low_wr)
                  stack_mem[gi][`PCRS_HIGH_LSB-1:`PCRS_LOW_LSB] <= wr_data;
               if (top_high_wr)
                  stack_mem[gi][`PCRS_UPPER_LSB-1:`PCRS_HIGH_LSB] <= wr_data;
               if (top_upper_wr)
                  stack_mem[gi][ADDR_W-1:`PCRS_UPPER_LSB] <= wr_data[`PCRS_UPPER_W-1:0];
            end
         end
      end
   endgenerate

   always @* begin
      fetch_addr           = pc_ff;
      fetch_addr_low_byte  = pc_ff[`PCRS_HIGH_LSB-1:`PCRS_LOW_LSB];
      high_byte_latch      = hlat_ff;
      upper_byte_latch     = ulat_ff;
      return_stack_pointer = ptr_ff;
      stack_top_upper      = top_val[ADDR_W-1:`PCRS_UPPER_LSB];
      stack_top_high       = top_val[`PCRS_UPPER_LSB-1:`PCRS_HIGH_LSB];
      stack_top_low        = top_val[`PCRS_HIGH_LSB-1:`PCRS_LOW_LSB];
      stack_full           = at_full;
      stack_overflow       = ovf_ff;
      stack_underflow      = unf_ff;
   end

endmodule

// [tb/pcrs_dec.sv]
/* pcrs_dec.sv: decoder model raising at most one core strobe per operation code.
   assumes: tb changes op just after a clock edge. */
`timescale 1ns/10ps
module pcrs_dec (
   input  wire logic [3:0]  op,   // 0 idle, n raises strobe n-1
   input  wire logic        gie,  // global interrupt enable
   output logic      [14:0] stb   // decoded strobes
);
   // acknowledge held off while software masks interrupts
   assign stb = (op == 4'h0 || (op == 4'h4 && !gie)) ? 15'h0000 : 15'h0001 << (op - 4'h1);
endmodule

// [tb/pcrs_core_asserts.sv]
/* pcrs_core_asserts.sv: port properties of the program counter and stack.
   assumes: bound to pcrs_core; one pc-changing strobe per cycle. */
`timescale 1ns/10ps
module pcrs_chk #(parameter DEPTH = 31) (
   input logic        clk,                  // clock
   input logic        rst,                  // reset
   input logic        advance,              // step
   input logic        load_direct,          // jump
   input logic [20:0] target_addr,          // target
   input logic        do_call,              // call
   input logic        int_ack,              // irq push
   input logic        do_return,            // pop
   input logic        low_wr,               // low write
   input logic        low_rd,               // low read
   input logic [7:0]  wr_data,              // data
   input logic        high_latch_wr,        // latch wr
   input logic        upper_latch_wr,       // latch wr
   input logic        ptr_wr,               // pointer wr
   input logic [20:0] fetch_addr,           // pc
   input logic [7:0]  high_byte_latch,      // latch
   input logic [4:0]  upper_byte_latch,     // latch
   input logic [4:0]  return_stack_pointer, // pointer
   input logic        stack_full,           // full
   input logic        stack_overflow,       // overflow
   input logic        stack_underflow       // underflow
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   wire push = do_call | int_ack;
   wire lw = high_latch_wr | upper_latch_wr;
   a_align_bit_zero: assert property (!fetch_addr[0]) else $error("odd fetch address");
   a_seq_step_two: assert property (advance && !push && !do_return && !low_wr && !load_direct
      |=> fetch_addr == $past(fetch_addr) + 21'h000002) else $error("bad step");
   a_direct_load: assert property (load_direct && !push && !do_return && !low_wr
      |=> fetch_addr == {$past(target_addr[20:1]), 1'b0}) else $error("bad direct load");
   a_low_wr_copy: assert property (low_wr && !push && !do_return && !lw
      |=> fetch_addr == {$past(upper_byte_latch), $past(high_byte_latch), $past(wr_data[7:1]), 1'b0})
      else $error("bad low write");
   a_low_rd_copy: assert property (low_rd && !lw
      |=> {upper_byte_latch, high_byte_latch} == $past(fetch_addr[20:8])) else $error("bad low read");
   a_push_then_load: assert property (push && !stack_full && !ptr_wr
      |=> return_stack_pointer == $past(return_stack_pointer) + 5'h01 && fetch_addr[0] == 1'b0)
      else $error("bad push");
   a_pop_decrement: assert property (do_return && !push && !ptr_wr && return_stack_pointer != 5'h00
      |=> return_stack_pointer == $past(return_stack_pointer) - 5'h01) else $error("bad pop");
   a_latch_untouched: assert property ((push || do_return) && !low_rd && !lw
      |=> $stable({upper_byte_latch, high_byte_latch})) else $error("latch moved");
   a_full_flag: assert property (stack_full == (return_stack_pointer == DEPTH)) else $error("bad full");
   a_overflow_held: assert property (push && stack_full && !ptr_wr
      |=> stack_overflow && return_stack_pointer == 5'h1F) else $error("bad overflow");
   a_underflow_held: assert property (do_return && !push && !ptr_wr && return_stack_pointer == 5'h00
      |=> stack_underflow && return_stack_pointer == 5'h00) else $error("bad underflow");
endmodule
bind pcrs_core pcrs_chk #(.DEPTH(DEPTH)) u_chk (.*);

// [tb/tb.sv]
/* tb.sv: directed bench for pcrs_core fed by the decoder model.
   assumes: one operation per clock, answers visible one cycle later. */
`timescale 1ns/10ps
module tb;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        gie = 1'b1;
   logic [3:0]  op_code = 4'h0;
   logic [7:0]  wr_data = 8'h00;
   logic [20:0] target_addr = 21'h000000;
   logic [14:0] stb;
   logic        advance, load_direct, do_call, int_ack, do_return, low_wr, low_rd, high_latch_wr;
   logic        upper_latch_wr, ptr_wr, top_upper_wr, top_high_wr, top_low_wr, clr_overflow, clr_underflow;
   logic [20:0] fetch_addr;
   logic [7:0]  fetch_addr_low_byte, high_byte_latch, stack_top_high, stack_top_low;
   logic [4:0]  upper_byte_latch, return_stack_pointer, stack_top_upper;
   logic        stack_full, stack_overflow, stack_underflow;
   integer      err_count = 0;
   integer      checked = 0;
   integer      i;
   assign {clr_underflow, clr_overflow, top_low_wr, top_high_wr, top_upper_wr, ptr_wr, upper_latch_wr,
           high_latch_wr, low_rd, low_wr, do_return, int_ack, do_call, load_direct, advance} = stb;
   pcrs_dec dec (.op(op_code), .gie(gie), .stb(stb));
   pcrs_core dut (.*);
   always #4 clk = ~clk;
   task automatic run(input logic [3:0] c, input logic [7:0] d, input logic [20:0] t);
      op_code = c;
      wr_data = d;
      target_addr = t;
      @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [20:0] g, input logic [20:0] e);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("Error t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic finish_test;
      $display("checks=%0d errors=%0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge clk);
      err_count++;
      finish_test();
   end
   initial begin
      repeat (8) @(posedge clk);
      #1 rst = 1'b0;
      chk(return_stack_pointer, 21'h0);
      repeat (3) run(4'h1, 8'h00, 21'h0);
      chk(fetch_addr, 21'h000006);
      run(4'h2, 8'h00, 21'h012345);
      chk(fetch_addr, 21'h012344);
      run(4'h8, 8'hAB, 21'h0);
      run(4'h9, 8'hFC, 21'h0);
      chk(fetch_addr, 21'h012344);
      run(4'h6, 8'h57, 21'h0);
      chk(fetch_addr, 21'h1CAB56);
      chk(fetch_addr_low_byte, 21'h56);
      run(4'h2, 8'h00, 21'h0A5502);
      run(4'h7, 8'h00, 21'h0);
      chk({upper_byte_latch, high_byte_latch}, 21'h0A55);
      // calls and acknowledges alternate; each pushes the address past itself
      for (i = 1; i <= 31; i++) begin
         run(i[0] ? 4'h3 : 4'h4, 8'h00, 21'(i * 256));
         chk(return_stack_pointer, 21'(i));
         chk({stack_top_upper, stack_top_high, stack_top_low}, (i == 1) ? 21'h0A5504 : 21'(i * 256 - 254));
         chk({upper_byte_latch, high_byte_latch}, 21'h0A55);
      end
      chk(stack_full, 21'h1);
      run(4'h3, 8'h00, 21'h1FFFFE);
      chk({stack_overflow, return_stack_pointer}, 21'h3F);
      chk({stack_top_upper, stack_top_high, stack_top_low}, 21'h001E02);
      gie = 1'b0;
      run(4'h4, 8'h00, 21'h000800);
      chk(return_stack_pointer, 21'h1F);
      run(4'hB, 8'h05, 21'h0);
      run(4'hC, 8'h66, 21'h0);
      run(4'hD, 8'h78, 21'h0);
      chk({stack_top_upper, stack_top_high, stack_top_low}, 21'h056678);
      run(4'h5, 8'h00, 21'h0);
      chk(fetch_addr, 21'h056678);
      chk(return_stack_pointer, 21'h1E);
      gie = 1'b1;
      for (i = 30; i >= 1; i--) begin
         run(4'h5, 8'h00, 21'h0);
         chk(fetch_addr, (i == 1) ? 21'h0A5504 : 21'(i * 256 - 254));
      end
      run(4'h5, 8'h00, 21'h0);
      chk({stack_underflow, return_stack_pointer}, 21'h20);
      run(4'hE, 8'h00, 21'h0);
      run(4'hF, 8'h00, 21'h0);
      chk({stack_overflow, stack_underflow}, 21'h0);
      run(4'hA, 8'h03, 21'h0);
      chk(return_stack_pointer, 21'h03);
      run(4'h0, 8'h00, 21'h0);
      rst = 1'b1;
      repeat (8) @(posedge clk);
      #1 rst = 1'b0;
      chk(return_stack_pointer, 21'h0);
      finish_test();
   end
endmodule
